/* File: pos_irq_enable.sv */
// interrupt enable set/clear registers, status flags and irq of the position decoder
// assumes an avalon-mm master on core_clk; event pulses and write guard are synchronous
//
// Our own choice: the Avalon-MM interface to the registers.
module pos_irq_enable #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic overflow_event,
    input wire logic error_event,
    input wire logic direction_event,
    input wire logic velocity_event,
    input wire logic match0_event,
    input wire logic match1_event,
    input wire logic peripheral_write_guard,
    output logic [1:0] operating_mode,
    output logic [5:0] effective_irq_en,
    output logic irq
);

    localparam int N = pos_irq_pkg::NUM_SRC;

    // bus handshake state
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // decoded access
    logic [ADDR_WIDTH-3:0] word_idx;
    logic hit_set;
    logic hit_clear;
    logic hit_status;
    logic hit_status_clear;
    logic hit_mode;
    logic wr_commit;
    logic wr_allowed;
    logic lane0;

    // enables, flags and mode
    logic [N-1:0] en_set_mask;
    logic [N-1:0] en_clear_mask;
    logic [N-1:0] en_bits;
    logic [N-1:0] st_clear_mask;
    logic [N-1:0] st_flags;
    logic [N-1:0] events;
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    logic [N-1:0] eff_en_ff;
    logic [N-1:0] nxt_eff_en;
    logic irq_ff;
    logic nxt_irq;

    assign word_idx = avs_address[ADDR_WIDTH-1:2];
    assign hit_set = (word_idx == pos_irq_pkg::IDX_ENABLE_SET[ADDR_WIDTH-3:0]);
    assign hit_clear = (word_idx == pos_irq_pkg::IDX_ENABLE_CLEAR_VIEW[ADDR_WIDTH-3:0]);
    assign hit_status = (word_idx == pos_irq_pkg::IDX_STATUS[ADDR_WIDTH-3:0]);
    assign hit_status_clear = (word_idx == pos_irq_pkg::IDX_STATUS_CLEAR[ADDR_WIDTH-3:0]);
    assign hit_mode = (word_idx == pos_irq_pkg::IDX_MODE[ADDR_WIDTH-3:0]);

    // a write lands only on the edge where waitrequest is low
    assign wr_commit = avs_write && !wait_ff;
    assign lane0 = avs_byteenable[0];
    // protected registers ignore writes while the guard is up
    assign wr_allowed = wr_commit && lane0 && !peripheral_write_guard;

    assign events[pos_irq_pkg::BIT_OVERFLOW] = overflow_event;
    assign events[pos_irq_pkg::BIT_ERROR] = error_event;
    assign events[pos_irq_pkg::BIT_DIRECTION] = direction_event;
    assign events[pos_irq_pkg::BIT_VELOCITY] = velocity_event;
    assign events[pos_irq_pkg::BIT_MATCH0] = match0_event;
    assign events[pos_irq_pkg::BIT_MATCH1] = match1_event;

    // write-one masks; a zero bit in write data selects nothing
    always_comb begin
        en_set_mask = '0;
        en_clear_mask = '0;
        st_clear_mask = '0;
        if (wr_allowed && hit_set) begin
            en_set_mask = avs_writedata[N-1:0];
        end
        if (wr_allowed && hit_clear) begin
            en_clear_mask = avs_writedata[N-1:0];
        end
        // status clear is not guarded so handlers can always acknowledge
        if (wr_commit && lane0 && hit_status_clear) begin
            st_clear_mask = avs_writedata[N-1:0];
        end
    end

    // one bank holds the enables seen through both set and clear views
    set_clear_bank #(
        .WIDTH(N),
        .RESET_VALUE(pos_irq_pkg::RST_ENABLE[N-1:0])
    ) u_enables (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set_mask(en_set_mask),
        .clear_mask(en_clear_mask),
        .bits(en_bits)
    );

    sticky_flags #(
        .WIDTH(N),
        .RESET_VALUE(pos_irq_pkg::RST_STATUS[N-1:0])
    ) u_status (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .event_pulse(events),
        .clear_mask(st_clear_mask),
        .flags(st_flags)
    );

    // mode register
    always_comb begin
        nxt_mode = mode_ff;
        if (wr_allowed && hit_mode) begin
            nxt_mode = avs_writedata[pos_irq_pkg::MODE_LSB +: pos_irq_pkg::MODE_WIDTH];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= pos_irq_pkg::RST_MODE;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // effective enables and the level interrupt
    always_comb begin
        nxt_eff_en = en_bits;
        if (mode_ff == pos_irq_pkg::MODE_COUNTER) begin
            nxt_eff_en = en_bits & ~pos_irq_pkg::MASK_MOTION;
        end
        nxt_irq = |(st_flags & nxt_eff_en);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            eff_en_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            eff_en_ff <= nxt_eff_en;
            irq_ff <= nxt_irq;
        end
    end

    // bus answer: one wait cycle, then read data and waitrequest low together
    always_comb begin
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        if ((avs_read || avs_write) && wait_ff) begin
            nxt_wait = 1'b0;
            nxt_rdata = '0;
            if (avs_read) begin
                if (hit_set || hit_clear) begin
                    nxt_rdata[N-1:0] = en_bits;
                end else if (hit_status) begin
                    nxt_rdata[N-1:0] = st_flags;
                end else if (hit_mode) begin
                    nxt_rdata[pos_irq_pkg::MODE_LSB +: pos_irq_pkg::MODE_WIDTH] = mode_ff;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_ff <= 1'b1;
            rdata_ff <= '0;
        end else begin
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;
    assign operating_mode = mode_ff;
    assign effective_irq_en = eff_en_ff;
    assign irq = irq_ff;

endmodule : pos_irq_enable

/* File: pos_irq_enable_properties.sv */
// bus, enable and irq properties of the position decoder interrupt enable block
// assumes the one-cycle avalon answer and enables registered one cycle behind the bank
module pos_irq_enable_properties #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic overflow_event,
    input wire logic peripheral_write_guard,
    input wire logic [1:0] operating_mode,
    input wire logic [5:0] effective_irq_en,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic set_ok;
    logic motion_on;
    assign set_ok = avs_write && !avs_waitrequest && avs_address == 8'h24 && avs_byteenable[0]
        && !peripheral_write_guard && motion_on;
    assign motion_on = operating_mode != pos_irq_pkg::MODE_COUNTER;
    answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    set_only_a: assert property (set_ok |-> ##2 effective_irq_en == ($past(effective_irq_en, 2)
        | $past(avs_writedata[5:0], 2))) else $error("enable set write gave wrong enables");
    counter_mask_a: assert property (!motion_on && $past(operating_mode) == pos_irq_pkg::MODE_COUNTER
        |-> (effective_irq_en & pos_irq_pkg::MASK_MOTION) == 6'h00) else $error("motion enable active");
    irq_gate_a: assert property (effective_irq_en == 6'h00 |-> !irq)
        else $error("irq without any enable");
    irq_raise_a: assert property (overflow_event && effective_irq_en[0] |-> ##[1:2] irq)
        else $error("enabled overflow gave no irq");
    enable_read_a: assert property (avs_read && !avs_waitrequest && avs_address[7:3] == 5'h04 && motion_on
        && $stable(operating_mode) |-> avs_readdata == {26'h0, effective_irq_en}) else $error("enable read");
    unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h3C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : pos_irq_enable_properties

bind pos_irq_enable pos_irq_enable_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.core_clk, .arst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .overflow_event, .peripheral_write_guard, .operating_mode, .effective_irq_en, .irq);

/* File: pos_irq_enable_tb.sv */
// self-checking bench for the position decoder interrupt enable block
// assumes byte addresses 0x20 clear, 0x24 set, 0x2C status clear, 0x30 mode
module pos_irq_enable_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic arst_n = 1'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic [5:0] ev = 6'h00;
    logic [5:0] eff;
    logic [1:0] mode;
    logic avs_waitrequest;
    logic irq;
    int fails = 0;
    int n_tests = 0;
    pos_irq_enable u_dut (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .overflow_event(ev[0]), .error_event(ev[1]),
        .direction_event(ev[2]), .velocity_event(ev[3]), .match0_event(ev[4]), .match1_event(ev[5]),
        .peripheral_write_guard(1'h0), .operating_mode(mode), .effective_irq_en(eff), .irq);
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    // waits on waitrequest, never on a fixed latency; only the watchdog ends a hang
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge core_clk);
    endtask : bus
    task pulse(input int i);
        ev <= 6'h01 << i;
        @(posedge core_clk);
        ev <= 6'h00;
        @(posedge core_clk);
    endtask : pulse
    task t_set;
        logic [5:0] acc;
        acc = 6'h00;
        bus(1'h0, 8'h24, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(1'h1, 8'h24, 32'h1 << i);
            acc |= 6'h01 << i;
            bus(1'h1, 8'h24, 32'h0);
            bus(1'h0, 8'h20, 32'h0);
            chk(q, {26'h0, acc});
        end
        bus(1'h1, 8'h20, 32'h3F);
        bus(1'h0, 8'h24, 32'h0);
        chk(q, 32'h0);
        $display("set test done");
    endtask : t_set
    task t_irq;
        bus(1'h1, 8'h24, 32'h01);
        pulse(1);
        @(posedge core_clk);
        chk(irq, 1'h0);
        bus(1'h0, 8'h28, 32'h0);
        chk(q, 32'h02);
        bus(1'h1, 8'h24, 32'h02);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'h1);
        bus(1'h1, 8'h2C, 32'h3F);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'h0);
        pulse(0);
        @(posedge core_clk);
        chk(irq, 1'h1);
        bus(1'h1, 8'h2C, 32'h3F);
        bus(1'h1, 8'h20, 32'h3F);
        $display("irq test done");
    endtask : t_irq
    task t_mode;
        bus(1'h1, 8'h30, 32'h2);
        chk(mode, 32'h2);
        bus(1'h0, 8'h30, 32'h0);
        chk(q, 32'h2);
        bus(1'h1, 8'h24, 32'h0C);
        repeat (2) @(posedge core_clk);
        chk(eff, 32'h0);
        pulse(3);
        @(posedge core_clk);
        chk(irq, 1'h0);
        bus(1'h0, 8'h24, 32'h0);
        chk(q, 32'h0C);
        bus(1'h1, 8'h30, 32'h0);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'h1);
        bus(1'h0, 8'h3C, 32'h0);
        chk(q, 32'h0);
        $display("mode test done");
    endtask : t_mode
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'h1;
        @(posedge core_clk);
        t_set();
        t_irq();
        t_mode();
        conclude();
    end
    initial begin
        #100000;
        fails++;
        conclude();
    end
endmodule : pos_irq_enable_tb

/* File: pos_irq_pkg.sv */
// constants for the position decoder interrupt enable block
// assumes a 32-bit avalon-mm slave port with byte addresses
package pos_irq_pkg;

    localparam int NUM_SRC = 6;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_ENABLE_CLEAR_VIEW = 8'h08;
    localparam logic [7:0] IDX_ENABLE_SET = 8'h09;
    localparam logic [7:0] IDX_STATUS = 8'h0A;
    localparam logic [7:0] IDX_STATUS_CLEAR = 8'h0B;
    localparam logic [7:0] IDX_MODE = 8'h0C;

    // bit positions shared by enables, status and clear
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_ERROR = 1;
    localparam int BIT_DIRECTION = 2;
    localparam int BIT_VELOCITY = 3;
    localparam int BIT_MATCH0 = 4;
    localparam int BIT_MATCH1 = 5;

    // mode field
    localparam int MODE_LSB = 0;
    localparam int MODE_WIDTH = 2;
    localparam logic [1:0] MODE_QUADRATURE = 2'h0;
    localparam logic [1:0] MODE_HALL = 2'h1;
    localparam logic [1:0] MODE_COUNTER = 2'h2;

    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [1:0] RST_MODE = 2'h0;

    // sources that are ignored in plain counting mode
    localparam logic [NUM_SRC-1:0] MASK_MOTION = 6'h0C;

endpackage : pos_irq_pkg

/* File: set_clear_bank.sv */
// bank of enable bits changed only by write-one-to-set and write-one-to-clear masks
// assumes both masks are single-cycle strobes from the same clock domain
module set_clear_bank #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] set_mask,
    input wire logic [WIDTH-1:0] clear_mask,
    output logic [WIDTH-1:0] bits
);

    logic [WIDTH-1:0] bits_ff;
    logic [WIDTH-1:0] nxt_bits;

    // zeros in either mask leave the bit alone; set beats clear
    always_comb begin
        nxt_bits = (bits_ff & ~clear_mask) | set_mask;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bits_ff <= RESET_VALUE;
        end else begin
            bits_ff <= nxt_bits;
        end
    end

    assign bits = bits_ff;

endmodule : set_clear_bank

/* File: sticky_flags.sv */
// sticky event flags: hardware pulses set, software mask clears
// assumes event pulses come from logic on the same clock
module sticky_flags #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] event_pulse,
    input wire logic [WIDTH-1:0] clear_mask,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;

    // an event in the clearing cycle is kept
    always_comb begin
        nxt_flags = (flags_ff & ~clear_mask) | event_pulse;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_ff <= RESET_VALUE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;

endmodule : sticky_flags
